// ---- rdc_ctrl_cfg.svh ----
// register offsets, field positions, masks and reset values of the converter control registers
`ifndef RDC_CTRL_CFG_SVH
`define RDC_CTRL_CFG_SVH
// ------------------------------------------------------------
// offsets
// ------------------------------------------------------------
`define STOP_CTRL_OFFSET 12'h000
`define GAIN_SEL0_OFFSET 12'h004
// ------------------------------------------------------------
// stop register fields
// ------------------------------------------------------------
`define STOP_RESET 32'h00000001
`define STOP_WMASK 32'h00001101
`define AMP_UNITY_BIT 12
`define MONITOR_EN_BIT 8
`define ANALOG_STOP_BIT 0
// ------------------------------------------------------------
// gain select 0 fields
// ------------------------------------------------------------
`define GAIN0_RESET 32'h00020010
`define GAIN0_WMASK 32'hF777FF17
`define VEL_METHOD_HI 31
`define VEL_METHOD_LO 30
`define DEV_WEIGHT_HI 29
`define DEV_WEIGHT_LO 28
`define PROP_QUAD_BIT 26
`define PROP_SEL_HI 25
`define PROP_SEL_LO 24
`define INT_SEL_HI 22
`define INT_SEL_LO 20
`define VAR_CLK_HI 18
`define VAR_CLK_LO 16
`define LOW_VGAIN_HI 15
`define LOW_VGAIN_LO 12
`define HIGH_VGAIN_HI 11
`define HIGH_VGAIN_LO 8
`define BW_SEL_BIT 4
`define LOOP_PRESET_HI 2
`define LOOP_PRESET_LO 0
`endif

// ---- rdc_ctrl_pkg.sv ----
// types shared by the converter control register block
package rdc_ctrl_pkg;
  typedef enum logic [1:0] {
    VG_AGC12,
    VG_AGC7,
    VG_AGC2,
    VG_FIXED
  } vel_method_e;
  typedef enum logic [1:0] {
    DW_X1,
    DW_X3,
    DW_X5,
    DW_X7
  } dev_weight_e;
  typedef enum logic [1:0] {
    KP_X1,
    KP_X0P25,
    KP_X0P5,
    KP_X2
  } prop_sel_e;
endpackage

// ---- resolver_converter_ctrl_regs.sv ----
// apb register bank for the resolver converter stop and gain select controls
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ns
`include "rdc_ctrl_cfg.svh"

// Overview of operation
// - registers accept 8, 16 and 32 bit accesses; bits placed as 32-bit word
// - reserved bits read back their reset value; software writes reset value
// - stop register resets to 0x00000001, analog section starts stopped
// - stop bit 12 forces the input amplifier to unity gain
// - stop bit 8 drives sine and cosine monitor pins when set and stop bit 0 is clear
// - stop bit 0 disables 5 V circuits and floats converter pins
// - gain select register 0 resets to 0x00020010
// - bits 31:30 select velocity gain method: 12-level, 7-level, 2-level, fixed
// - bits 29:28 weight error deviation by x1, x3, x5 or x7
// - bit 26 quadruples proportional gain when set
// - bits 25:24 select proportional gain x1, x0.25, x0.5, x2
// - bits 22:20 select integral gain x1 through x16
// - bit 4 selects loop gain preset in bits 2:0 over individual fields
module resolver_converter_ctrl_regs
  import rdc_ctrl_pkg::*;
(
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog front end controls
  output logic amp_unity_gain,
  output logic monitor_pin_enable,
  output logic analog_stop,
  // tracking loop controls
  output vel_method_e velocity_gain_method,
  output dev_weight_e deviation_weight,
  output logic prop_gain_quadruple,
  output prop_sel_e prop_gain_select,
  output logic [2:0] integral_gain_select,
  output logic [2:0] var_clock_select,
  output logic [3:0] low_velocity_gain,
  output logic [3:0] high_velocity_gain,
  output logic bandwidth_setting_select,
  output logic [2:0] loop_gain_preset,
  output logic loop_use_preset
);

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  localparam logic [31:0] STOP_INIT = `STOP_RESET;
  localparam logic [31:0] GAIN0_INIT = `GAIN0_RESET;

  logic setup;
  logic wr_en;
  logic hit_stop;
  logic hit_gain0;
  logic [3:0] stop_lane_we;
  logic [3:0] gain0_lane_we;
  logic [31:0] stop_word;
  logic [31:0] gain0_word;
  logic [31:0] rd_d;

  // stop register fields
  logic amp_unity_q;
  logic monitor_en_q;
  logic analog_stop_q;

  // gain select 0 fields
  logic [1:0] vel_method_q;
  logic [1:0] dev_weight_q;
  logic prop_quad_q;
  logic [1:0] prop_sel_q;
  logic [2:0] int_sel_q;
  logic [2:0] var_clk_q;
  logic [3:0] low_vgain_q;
  logic [3:0] high_vgain_q;
  logic bw_sel_q;
  logic [2:0] loop_preset_q;

  // one-cycle setup decode; the access phase then completes with no wait state
  assign setup = psel & ~penable;
  assign hit_stop = (paddr == `STOP_CTRL_OFFSET);
  assign hit_gain0 = (paddr == `GAIN_SEL0_OFFSET);
  // a write lands only in an access phase that this block answered, never on a stray penable
  assign wr_en = psel & penable & pwrite & pready;

  // each field sits inside one byte lane, so a single strobe bit gates it
  assign stop_lane_we = {4{wr_en & hit_stop}} & pstrb;
  assign gain0_lane_we = {4{wr_en & hit_gain0}} & pstrb;

  // ------------------------------------------------------------
  // stop register fields
  // ------------------------------------------------------------
  // only writable bits own a flop; reserved bits are tied off in the read word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      amp_unity_q <= STOP_INIT[`AMP_UNITY_BIT];
    end else if (stop_lane_we[`AMP_UNITY_BIT / 8]) begin
      amp_unity_q <= pwdata[`AMP_UNITY_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      monitor_en_q <= STOP_INIT[`MONITOR_EN_BIT];
    end else if (stop_lane_we[`MONITOR_EN_BIT / 8]) begin
      monitor_en_q <= pwdata[`MONITOR_EN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_stop_q <= STOP_INIT[`ANALOG_STOP_BIT];
    end else if (stop_lane_we[`ANALOG_STOP_BIT / 8]) begin
      analog_stop_q <= pwdata[`ANALOG_STOP_BIT];
    end
  end

  // ------------------------------------------------------------
  // gain select 0 fields
  // ------------------------------------------------------------
  // a narrow write moves only the fields of its lanes, the others hold
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vel_method_q <= GAIN0_INIT[`VEL_METHOD_HI:`VEL_METHOD_LO];
    end else if (gain0_lane_we[`VEL_METHOD_LO / 8]) begin
      vel_method_q <= pwdata[`VEL_METHOD_HI:`VEL_METHOD_LO];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dev_weight_q <= GAIN0_INIT[`DEV_WEIGHT_HI:`DEV_WEIGHT_LO];
    end else if (gain0_lane_we[`DEV_WEIGHT_LO / 8]) begin
      dev_weight_q <= pwdata[`DEV_WEIGHT_HI:`DEV_WEIGHT_LO];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prop_quad_q <= GAIN0_INIT[`PROP_QUAD_BIT];
    end else if (gain0_lane_we[`PROP_QUAD_BIT / 8]) begin
      prop_quad_q <= pwdata[`PROP_QUAD_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prop_sel_q <= GAIN0_INIT[`PROP_SEL_HI:`PROP_SEL_LO];
    end else if (gain0_lane_we[`PROP_SEL_LO / 8]) begin
      prop_sel_q <= pwdata[`PROP_SEL_HI:`PROP_SEL_LO];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_sel_q <= GAIN0_INIT[`INT_SEL_HI:`INT_SEL_LO];
    end else if (gain0_lane_we[`INT_SEL_LO / 8]) begin
      int_sel_q <= pwdata[`INT_SEL_HI:`INT_SEL_LO];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      var_clk_q <= GAIN0_INIT[`VAR_CLK_HI:`VAR_CLK_LO];
    end else if (gain0_lane_we[`VAR_CLK_LO / 8]) begin
      var_clk_q <= pwdata[`VAR_CLK_HI:`VAR_CLK_LO];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_vgain_q <= GAIN0_INIT[`LOW_VGAIN_HI:`LOW_VGAIN_LO];
    end else if (gain0_lane_we[`LOW_VGAIN_LO / 8]) begin
      low_vgain_q <= pwdata[`LOW_VGAIN_HI:`LOW_VGAIN_LO];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_vgain_q <= GAIN0_INIT[`HIGH_VGAIN_HI:`HIGH_VGAIN_LO];
    end else if (gain0_lane_we[`HIGH_VGAIN_LO / 8]) begin
      high_vgain_q <= pwdata[`HIGH_VGAIN_HI:`HIGH_VGAIN_LO];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bw_sel_q <= GAIN0_INIT[`BW_SEL_BIT];
    end else if (gain0_lane_we[`BW_SEL_BIT / 8]) begin
      bw_sel_q <= pwdata[`BW_SEL_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loop_preset_q <= GAIN0_INIT[`LOOP_PRESET_HI:`LOOP_PRESET_LO];
    end else if (gain0_lane_we[`LOOP_PRESET_LO / 8]) begin
      loop_preset_q <= pwdata[`LOOP_PRESET_HI:`LOOP_PRESET_LO];
    end
  end

  // ------------------------------------------------------------
  // read words
  // ------------------------------------------------------------
  // reserved and read-only bits come from the reset constant, so no write can move them
  always_comb begin
    stop_word = STOP_INIT & ~`STOP_WMASK;
    stop_word[`AMP_UNITY_BIT] = amp_unity_q;
    stop_word[`MONITOR_EN_BIT] = monitor_en_q;
    stop_word[`ANALOG_STOP_BIT] = analog_stop_q;
  end

  always_comb begin
    gain0_word = GAIN0_INIT & ~`GAIN0_WMASK;
    gain0_word[`VEL_METHOD_HI:`VEL_METHOD_LO] = vel_method_q;
    gain0_word[`DEV_WEIGHT_HI:`DEV_WEIGHT_LO] = dev_weight_q;
    gain0_word[`PROP_QUAD_BIT] = prop_quad_q;
    gain0_word[`PROP_SEL_HI:`PROP_SEL_LO] = prop_sel_q;
    gain0_word[`INT_SEL_HI:`INT_SEL_LO] = int_sel_q;
    gain0_word[`VAR_CLK_HI:`VAR_CLK_LO] = var_clk_q;
    gain0_word[`LOW_VGAIN_HI:`LOW_VGAIN_LO] = low_vgain_q;
    gain0_word[`HIGH_VGAIN_HI:`HIGH_VGAIN_LO] = high_vgain_q;
    gain0_word[`BW_SEL_BIT] = bw_sel_q;
    gain0_word[`LOOP_PRESET_HI:`LOOP_PRESET_LO] = loop_preset_q;
  end

  // ------------------------------------------------------------
  // apb answer
  // ------------------------------------------------------------
  always_comb begin
    rd_d = 32'h00000000;
    if (hit_stop) begin
      rd_d = stop_word;
    end else if (hit_gain0) begin
      rd_d = gain0_word;
    end
  end

  // read data and response are registered in the setup cycle so they stand in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup & ~(hit_stop | hit_gain0);
    end
  end

  // the bus reads zero outside the access cycle, so no stale word lingers on it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else begin
      prdata <= (setup && !pwrite) ? rd_d : 32'h00000000;
    end
  end

  // ------------------------------------------------------------
  // control outputs
  // ------------------------------------------------------------
  // outputs follow the fields one cycle later, the cost of driving them from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      amp_unity_gain <= 1'b0;
    end else begin
      amp_unity_gain <= amp_unity_q;
    end
  end

  // a stopped converter floats its pins, so the monitor drive is held off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      monitor_pin_enable <= 1'b0;
    end else begin
      monitor_pin_enable <= monitor_en_q & ~analog_stop_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_stop <= 1'b1;
    end else begin
      analog_stop <= analog_stop_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      velocity_gain_method <= VG_AGC12;
      deviation_weight <= DW_X1;
    end else begin
      velocity_gain_method <= vel_method_e'(vel_method_q);
      deviation_weight <= dev_weight_e'(dev_weight_q);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prop_gain_quadruple <= 1'b0;
      prop_gain_select <= KP_X1;
      integral_gain_select <= 3'h0;
    end else begin
      prop_gain_quadruple <= prop_quad_q;
      prop_gain_select <= prop_sel_e'(prop_sel_q);
      integral_gain_select <= int_sel_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      var_clock_select <= 3'h2;
      low_velocity_gain <= 4'h0;
      high_velocity_gain <= 4'h0;
    end else begin
      var_clock_select <= var_clk_q;
      low_velocity_gain <= low_vgain_q;
      high_velocity_gain <= high_vgain_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bandwidth_setting_select <= 1'b1;
      loop_gain_preset <= 3'h0;
      loop_use_preset <= 1'b1;
    end else begin
      bandwidth_setting_select <= bw_sel_q;
      loop_gain_preset <= loop_preset_q;
      // no overflow guard: forbidden gain mixes are left to software
      loop_use_preset <= bw_sel_q;
    end
  end

endmodule

// ---- rdc_ctrl_props.sv ----
// checker of the converter control register bank
`timescale 1ns/1ns
module rdc_ctrl_props (
  // apb
  input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic [3:0] pstrb,
  // front end
  input wire logic analog_stop, amp_unity_gain, monitor_pin_enable
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic acc = psel && penable && pready;
  wire logic sw = acc && pwrite && paddr == 12'h000;
  a_ready_next: assert property (psel && !penable |=> pready) else $error("ready late");
  a_ready_pulse: assert property (pready |-> penable ##1 !pready) else $error("ready long");
  a_stop_bit: assert property (sw && pstrb[0] |-> ##2 analog_stop == $past(pwdata[0], 2))
    else $error("stop");
  a_unity_bit: assert property (sw && pstrb[1] |-> ##2 amp_unity_gain == $past(pwdata[12], 2))
    else $error("unity");
  a_lane_keep: assert property (sw && !pstrb[0] |-> ##2 $stable(analog_stop)) else $error("lane");
  a_monitor_gated: assert property (analog_stop |-> !monitor_pin_enable) else $error("monitor");
  a_reserved_zero: assert property (acc && !pwrite && paddr == 12'h000 |-> !(prdata & 32'hFFFFEEFE))
    else $error("reserved");
  a_unmapped_err: assert property (acc && paddr[11:3] != 9'h0 |-> pslverr) else $error("unmapped");
  cover property (sw);
  cover property (acc && pslverr);
  cover property ($rose(presetn));
endmodule
bind resolver_converter_ctrl_regs rdc_ctrl_props chk (.pclk, .presetn, .psel, .penable, .pwrite, .pready,
  .pslverr, .paddr, .pwdata, .prdata, .pstrb, .analog_stop, .amp_unity_gain, .monitor_pin_enable);

// ---- rdc_apb_host.sv ----
// apb master standing in for the cpu
`timescale 1ns/1ns
module rdc_apb_host (
  input wire logic pclk, pready, pslverr,
  input wire logic [31:0] prdata,
  output logic psel, penable, pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb
);
  initial {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
  task automatic xfer(logic [11:0] a, logic w, logic [31:0] d, logic [3:0] s, output logic [31:0] r,
    output logic e);
    {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, w, a, d, s};
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    // released lines show junk, not the old value
    {psel, penable, paddr, pwdata} <= {2'b0, ~a, ~d};
  endtask
endmodule

// ---- resolver_converter_ctrl_regs_test.sv ----
// bench of the converter control register bank
`timescale 1ns/1ns
module resolver_converter_ctrl_regs_test;
  logic pclk = 0, presetn = 0;
  logic psel, penable, pwrite, pready, pslverr, e, amp_unity_gain, monitor_pin_enable, analog_stop;
  logic prop_gain_quadruple, bandwidth_setting_select, loop_use_preset;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, es, eg, r, lf;
  logic [3:0] pstrb, low_velocity_gain, high_velocity_gain;
  logic [2:0] integral_gain_select, var_clock_select, loop_gain_preset;
  logic [1:0] velocity_gain_method, deviation_weight, prop_gain_select;
  logic we;
  int bad_count, num_checks, cyc;
  resolver_converter_ctrl_regs DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .amp_unity_gain, .monitor_pin_enable, .analog_stop, .velocity_gain_method,
    .deviation_weight, .prop_gain_quadruple, .prop_gain_select, .integral_gain_select, .var_clock_select,
    .low_velocity_gain, .high_velocity_gain, .bandwidth_setting_select, .loop_gain_preset, .loop_use_preset);
  rdc_apb_host h (.pclk, .pready, .pslverr, .prdata, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb);
  function automatic logic [31:0] nxt(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // only enabled lanes and writable bits move
  function automatic logic [31:0] mrg(logic [31:0] o, n, m, logic [3:0] s);
    for (int i = 0; i < 4; i++) if (s[i]) o[8*i+:8] = o[8*i+:8] & ~m[8*i+:8] | n[8*i+:8] & m[8*i+:8];
    return o;
  endfunction
  task chk(string n, logic [31:0] x, g);
    num_checks++;
    if (g !== x) begin
      bad_count++;
      $display("BAD %s exp %h got %h", n, x, g);
    end
  endtask
  task cmp;
    h.xfer(0, 0, 0, 0, r, e);
    @(posedge pclk);
    chk("stop", es, r);
    h.xfer(4, 0, 0, 0, r, e);
    @(posedge pclk);
    chk("gain", eg, r);
    chk("gain err", 0, e);
    chk("pins", eg, {velocity_gain_method, deviation_weight, 1'b0, prop_gain_quadruple, prop_gain_select,
      1'b0, integral_gain_select, 1'b0, var_clock_select, low_velocity_gain, high_velocity_gain, 3'b0,
      loop_use_preset, 1'b0, loop_gain_preset});
    chk("bw", eg[4], bandwidth_setting_select);
    chk("front", {es[12], es[8] & ~es[0], es[0]}, {amp_unity_gain, monitor_pin_enable, analog_stop});
  endtask
  task wr(logic [11:0] a, logic [31:0] d, logic [3:0] s);
    h.xfer(a, 1, d, s, r, e);
    we = e;
    chk("wr err", a != 0 && a != 4, e);
    @(posedge pclk);
    if (a == 0) es = mrg(es, d, 32'h1101, s);
    if (a == 4) eg = mrg(eg, d, 32'hF777FF17, s);
    cmp;
  endtask
  task results;
    $display("checks %0d bad %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial forever #50 pclk = ~pclk;
  always @(posedge pclk) if (++cyc == 3000) begin
    bad_count++;
    results;
  end
  initial begin
    lf = 32'hF50C;
    es = 32'h1;
    eg = 32'h20010;
    repeat (5) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    cmp;
    wr(0, '1, 4'hF);
    wr(0, 0, 4'h2);
    wr(0, 0, 4'h1);
    wr(8, '1, 4'hF);
    chk("err", 1, we);
    h.xfer(12'h008, 0, 0, 0, r, e);
    @(posedge pclk);
    chk("unmapped rd", 0, r);
    chk("rd err", 1, e);
    // codes paired so that no overflowing gain mix is written
    for (int c = 0; c < 8; c++)
      wr(4, c % 4 * 32'h50000000 | (c == 5) * 32'h4000000 | (3 - c % 4) << 24 | c << 20 | c % 2 << 4 | c, 4'hF);
    repeat (30) begin
      lf = nxt(lf);
      wr(lf[5] * 4, lf & (lf[5] ? 32'h7FF17 : 32'h1101), lf[31:28]);
    end
    presetn <= 0;
    @(posedge pclk);
    presetn <= 1;
    es = 32'h1;
    eg = 32'h20010;
    @(posedge pclk);
    cmp;
    results;
  end
endmodule
